// File: shared/pwt_pkg.sv
package pwt_pkg;
   // Register indices (byte registers, byte address = 4 * index)
   localparam logic [9:0] IDX_CTL = 10'h2f0;
   localparam logic [9:0] IDX_RATE_H = 10'h2f1;
   localparam logic [9:0] IDX_RATE_L = 10'h2f2;
   localparam logic [9:0] IDX_TRIM = 10'h2f3;
   localparam logic [9:0] IDX_TEST3 = 10'h2f6;
   localparam logic [9:0] IDX_IRQ_STAT = 10'h2f8;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h2f9;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   // Control bit positions
   localparam int CTL_SRC = 7;
   localparam int CTL_WAVE = 4;
   localparam int CTL_EXT = 3;
   localparam int CTL_FE = 2;
   localparam int CTL_IE = 1;
   localparam int CTL_FLAG = 0;
   // Trim field position
   localparam int TRIM_LSB = 2;
   localparam int TRIM_W = 6;
   // Reset values
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [15:0] RATE_RST = 16'h0000;
   localparam logic [7:0] TEST3_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   // Status bits of the sticky event register
   localparam int EV_TIMEOUT = 0;
   localparam int EV_W = 1;
   // Slow clock: 20 kHz nominal, one tick per slow half period
   localparam int SLOW_HZ_NOM = 20000;
   localparam int MCLK_HZ = 100000000;
   localparam int SLOW_TICK_CYC = MCLK_HZ / (2 * SLOW_HZ_NOM);
   localparam int TRIM_STEP_CYC = 8;
   localparam int SYNC_LAT = 2;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } pwt_req_t;

   typedef enum logic [0:0] {PWT_PULSE, PWT_CLOCK} pwt_wave_t;
endpackage

// File: rtl/pwt_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
// Slow RC clock model: tick every half period, length set by signed trim
module pwt_tick_gen #(
   parameter int BASE = 2500,
   parameter int STEP = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [5:0] trim,
   output logic tick
);
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   logic [15:0] limit;
   logic [15:0] inc;
   logic [15:0] dec;
   // Bit 5 lengthens, lower bits shorten with binary weights
   assign inc = trim[5] ? 16'(STEP * 32) : 16'h0000;
   assign dec = 16'(STEP) * {11'h000, trim[4:0]};
   assign limit = 16'(BASE) + inc - dec - 16'h0001;
   assign nxt_cnt = (!run || cnt_ff >= limit) ? 16'h0000 : cnt_ff + 16'h0001;
   // Free counter while running
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 16'h0000;
         tick <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         tick <= run && (cnt_ff >= limit);
      end
   end
endmodule
`default_nettype wire

// File: rtl/pwt_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (R1) Control bit 7 picks slow or bus clock
// (R2) Source select writable only while disabled
// (R3) Control bit 2 enables and starts timer
// (R4) Interrupt request when flag and enable set
// (R5) Flag set each elapsed period
// (R6) Flag cleared only by writing one
// (R7) Wave output needs external and feature enable
// (R8) Pulse mode: half minimum period high pulse
// (R9) Clock mode: output period twice timer period
// (R10) Rate writes ignored while enabled
// (R11) Bus clock period is 2*(rate+1) cycles
// (R12) Slow period is 2*(rate+1)*2 slow periods
// (R13) Slow start delayed by gate release
// (R14) Trim bits 7..2 hold signed value
// (R15) Trim bit 5 lengthens, lower bits shorten
// (R16) Trim loads from flash at reset release
// (R17) Test register writable only in special mode
// (R18) Wave select 0 pulse, 1 clock
// (R19) Counter reloads and repeats after time-out
module pwt_timer
   import pwt_pkg::*;
#(
   parameter int SLOW_TICK = SLOW_TICK_CYC,
   parameter int TRIM_STEP = TRIM_STEP_CYC
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [pwt_pkg::ADDR_W-1:0] addr,
   input wire logic [pwt_pkg::DATA_W-1:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [pwt_pkg::DATA_W-1:0] rdata,
   input wire logic special_mode,
   input wire logic [7:0] flash_trim,
   output logic wave_output_pin,
   output logic timeout_irq,
   output logic irq
);
   import pwt_pkg::*;

   // Reset release through two flops
   logic rst_s1_ff;
   logic rst_n_ff;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_n_ff <= rst_s1_ff;
      end
   end

   // Special mode strap passes three flops, change counts on 2nd/3rd agree
   logic [2:0] spec_sync_ff;
   logic spec_ff;
   always_ff @(posedge mclk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         spec_sync_ff <= 3'h0;
         spec_ff <= 1'b0;
      end else begin
         spec_sync_ff <= {spec_sync_ff[1:0], special_mode};
         if (spec_sync_ff[1] == spec_sync_ff[2]) begin
            spec_ff <= spec_sync_ff[2];
         end
      end
   end

   pwt_req_t req;
   assign req = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};

   // Register state
   logic source_select_ff;
   logic wave_select_ff;
   logic external_wave_enable_ff;
   logic feature_enable_ff;
   logic timeout_irq_enable_ff;
   logic timeout_flag_ff;
   logic [15:0] rate_value_ff;
   logic [7:0] trim_reg_ff;
   logic trim_loaded_ff;
   logic [7:0] test3_ff;
   logic [EV_W-1:0] ev_stat_ff;
   logic [EV_W-1:0] ev_mask_ff;

   // Address decode
   logic [9:0] idx;
   logic word_ok;
   logic wr_ctl, wr_rh, wr_rl, wr_trim, wr_test, wr_stat, wr_mask;
   logic [7:0] wb;
   assign idx = req.addr[11:2];
   assign word_ok = (req.addr[1:0] == 2'b00);
   assign wb = req.wdata[7:0];
   assign wr_ctl = req.wr && word_ok && idx == IDX_CTL;
   assign wr_rh = req.wr && word_ok && idx == IDX_RATE_H;
   assign wr_rl = req.wr && word_ok && idx == IDX_RATE_L;
   assign wr_trim = req.wr && word_ok && idx == IDX_TRIM;
   assign wr_test = req.wr && word_ok && idx == IDX_TEST3;
   assign wr_stat = req.wr && word_ok && idx == IDX_IRQ_STAT;
   assign wr_mask = req.wr && word_ok && idx == IDX_IRQ_MASK;

   // Timer core signals
   logic timeout;
   logic use_slow;
   logic slow_tick;
   logic step;
   logic [16:0] cnt_ff;
   logic [16:0] nxt_cnt;
   logic [16:0] period_steps;
   logic [1:0] gate_ff;
   logic gate_open;
   logic [5:0] trim_field;
   logic [1:0] pre_ff;
   logic slow_step;

   // Source select frozen while enabled, and in the enabling write
   logic nxt_src;
   assign nxt_src = (wr_ctl && !feature_enable_ff && !wb[CTL_FE]) ?
                    wb[CTL_SRC] : source_select_ff; // [R2]

   // Control register
   always_ff @(posedge mclk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         source_select_ff <= CTL_RST[CTL_SRC];
         wave_select_ff <= CTL_RST[CTL_WAVE];
         external_wave_enable_ff <= CTL_RST[CTL_EXT];
         feature_enable_ff <= CTL_RST[CTL_FE];
         timeout_irq_enable_ff <= CTL_RST[CTL_IE];
      end else begin
         source_select_ff <= nxt_src;
         if (wr_ctl) begin
            wave_select_ff <= wb[CTL_WAVE];
            external_wave_enable_ff <= wb[CTL_EXT];
            feature_enable_ff <= wb[CTL_FE]; // [R3]
            timeout_irq_enable_ff <= wb[CTL_IE];
         end
      end
   end

   // Time-out flag: set wins over write-one clear
   logic nxt_flag;
   assign nxt_flag = timeout ||
                     (timeout_flag_ff && !(wr_ctl && wb[CTL_FLAG])); // [R5] [R6]
   always_ff @(posedge mclk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         timeout_flag_ff <= CTL_RST[CTL_FLAG];
      end else begin
         timeout_flag_ff <= nxt_flag;
      end
   end

   // Rate value, locked while enabled
   always_ff @(posedge mclk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         rate_value_ff <= RATE_RST;
      end else if (!feature_enable_ff) begin // [R10]
         if (wr_rh) begin
            rate_value_ff[15:8] <= wb;
         end
         if (wr_rl) begin
            rate_value_ff[7:0] <= wb;
         end
      end
   end

   // Trim loads from flash once after reset release
   always_ff @(posedge mclk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         trim_reg_ff <= 8'h00;
         trim_loaded_ff <= 1'b0;
      end else begin
         trim_loaded_ff <= 1'b1;
         if (!trim_loaded_ff) begin
            trim_reg_ff <= flash_trim; // [R16]
         end else if (wr_trim) begin
            trim_reg_ff <= wb;
         end
      end
   end

   // Factory test register
   always_ff @(posedge mclk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         test3_ff <= TEST3_RST;
      end else if (wr_test && spec_ff) begin // [R17]
         test3_ff <= wb;
      end
   end

   // Sticky event status and mask
   logic [EV_W-1:0] ev_set;
   logic [EV_W-1:0] nxt_stat;
   assign ev_set = {{(EV_W-1){1'b0}}, timeout};
   assign nxt_stat = ev_set |
                     (ev_stat_ff & ~(wr_stat ? wb[EV_W-1:0] : '0));
   always_ff @(posedge mclk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         ev_stat_ff <= '0;
         ev_mask_ff <= MASK_RST[EV_W-1:0];
      end else begin
         ev_stat_ff <= nxt_stat;
         if (wr_mask) begin
            ev_mask_ff <= wb[EV_W-1:0];
         end
      end
   end

   // Slow clock tick source, trimmed
   assign trim_field = trim_reg_ff[TRIM_LSB +: TRIM_W]; // [R14]
   assign use_slow = feature_enable_ff && !source_select_ff; // [R1]
   pwt_tick_gen #(
      .BASE(SLOW_TICK),
      .STEP(TRIM_STEP)
   ) u_slow (
      .mclk(mclk),
      .rst_n(rst_n_ff),
      .run(use_slow),
      .trim(trim_field), // [R15]
      .tick(slow_tick)
   );

   // Gate opens after two ticks, then ticks are divided by four
   always_ff @(posedge mclk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         gate_ff <= 2'b00;
         pre_ff <= 2'b00;
      end else if (!use_slow) begin
         gate_ff <= 2'b00;
         pre_ff <= 2'b00;
      end else if (slow_tick && !gate_open) begin
         gate_ff <= {gate_ff[0], 1'b1}; // [R13]
      end else if (slow_tick) begin
         pre_ff <= pre_ff + 2'b01;
      end
   end
   assign gate_open = gate_ff[1];
   assign slow_step = slow_tick && gate_open && (pre_ff == 2'b11); // [R12]

   // One count step per bus cycle or per four slow half periods
   assign step = feature_enable_ff &&
                 (source_select_ff ? 1'b1 : slow_step); // [R1]
   // 2*(rate+1) steps; a slow step is two slow clock periods
   assign period_steps = {rate_value_ff, 1'b1}; // [R11] [R12]
   assign timeout = step && (cnt_ff >= period_steps);
   assign nxt_cnt = !feature_enable_ff ? 17'h00000 :
                    timeout ? 17'h00000 :
                    step ? cnt_ff + 17'h00001 : cnt_ff; // [R19]
   always_ff @(posedge mclk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         cnt_ff <= 17'h00000;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // Waveform generation
   logic clk_wave_ff;
   logic pulse_ff;
   logic wave_sel;
   always_ff @(posedge mclk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         clk_wave_ff <= 1'b0;
         pulse_ff <= 1'b0;
      end else begin
         if (!feature_enable_ff) begin
            clk_wave_ff <= 1'b0;
         end else if (timeout) begin
            clk_wave_ff <= ~clk_wave_ff; // [R9]
         end
         // High for one step: half of the two-step minimum period
         if (timeout) begin
            pulse_ff <= 1'b1; // [R8]
         end else if (step || !feature_enable_ff) begin
            pulse_ff <= 1'b0;
         end
      end
   end
   assign wave_sel = (pwt_wave_t'(wave_select_ff) == PWT_CLOCK) ?
                     clk_wave_ff : pulse_ff; // [R18]

   // Registered outputs
   always_ff @(posedge mclk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         wave_output_pin <= 1'b0;
         timeout_irq <= 1'b0;
         irq <= 1'b0;
      end else begin
         wave_output_pin <= external_wave_enable_ff && feature_enable_ff &&
                            wave_sel; // [R7]
         timeout_irq <= timeout_irq_enable_ff && nxt_flag; // [R4]
         irq <= |(nxt_stat & ev_mask_ff);
      end
   end

   // Read mux, data one cycle after strobe
   logic [7:0] rd_mux;
   logic [7:0] ctl_rd;
   assign ctl_rd = {source_select_ff, 2'b00, wave_select_ff,
                    external_wave_enable_ff, feature_enable_ff,
                    timeout_irq_enable_ff, timeout_flag_ff};
   assign rd_mux = !word_ok ? 8'h00 :
                   idx == IDX_CTL ? ctl_rd :
                   idx == IDX_RATE_H ? rate_value_ff[15:8] :
                   idx == IDX_RATE_L ? rate_value_ff[7:0] :
                   idx == IDX_TRIM ? {trim_reg_ff[7:2], 2'b00} :
                   idx == IDX_TEST3 ? test3_ff :
                   idx == IDX_IRQ_STAT ? {{(8-EV_W){1'b0}}, ev_stat_ff} :
                   idx == IDX_IRQ_MASK ? {{(8-EV_W){1'b0}}, ev_mask_ff} :
                   8'h00;
   always_ff @(posedge mclk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         rdata <= 32'h0000_0000;
      end else if (req.rd) begin
         rdata <= {24'h000000, rd_mux};
      end else begin
         rdata <= 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// File: tb/pwt_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pwt_timer_properties
   import pwt_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [pwt_pkg::ADDR_W-1:0] addr,
   input wire logic [pwt_pkg::DATA_W-1:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [pwt_pkg::DATA_W-1:0] rdata,
   input wire logic special_mode,
   input wire logic [7:0] flash_trim,
   input wire logic wave_output_pin,
   input wire logic timeout_irq,
   input wire logic irq
);
   logic fe_ff, ie_ff, ext_ff, wav_ff, src_ff;
   logic msk_ff, ok_ff, pin_ff, gate_ff;
   logic [15:0] rate_ff;
   logic [17:0] cnt_ff;
   logic [3:0] off_ff;
   // Decoded writes and waveform edge events
   wire logic w_ctl = wr_stb && addr == {IDX_CTL, 2'b00};
   wire logic w_rh = wr_stb && addr == {IDX_RATE_H, 2'b00} && !fe_ff;
   wire logic w_rl = wr_stb && addr == {IDX_RATE_L, 2'b00} && !fe_ff;
   wire logic w_msk = wr_stb && addr == {IDX_IRQ_MASK, 2'b00};
   wire logic clr1 = w_ctl && wdata[0];
   wire logic tgl = wav_ff ? wave_output_pin != pin_ff
      : wave_output_pin && !pin_ff;
   wire logic ev = src_ff && ext_ff && fe_ff && tgl;
   // Shadow of control, rate and mask; gap counter between events
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         {src_ff, wav_ff, ext_ff, fe_ff, ie_ff} <= '0;
         {msk_ff, ok_ff, pin_ff, gate_ff} <= '0;
         rate_ff <= RATE_RST;
         cnt_ff <= '0;
         off_ff <= '0;
      end else begin
         if (w_ctl) begin
            {wav_ff, ext_ff, fe_ff, ie_ff} <= wdata[4:1];
            src_ff <= (fe_ff || wdata[2]) ? src_ff : wdata[7];
         end
         if (w_rh) rate_ff[15:8] <= wdata[7:0];
         if (w_rl) rate_ff[7:0] <= wdata[7:0];
         if (w_msk) msk_ff <= wdata[0];
         pin_ff <= wave_output_pin;
         gate_ff <= ext_ff && fe_ff;
         cnt_ff <= ev ? '0 : cnt_ff + 18'h1;
         ok_ff <= !wr_stb && (ev || ok_ff);
         off_ff <= fe_ff ? '0 : off_ff + {3'h0, off_ff != 4'hf};
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   property p_irq_gate;
      timeout_irq |-> $past(ie_ff);
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("timeout request without enable");
   property p_pin_gate;
      wave_output_pin |-> gate_ff || $past(gate_ff);
   endproperty
   a_pin_gate: assert property (p_pin_gate)
      else $error("wave pin active while gated");
   property p_period;
      ev && ok_ff |-> cnt_ff == {1'b0, rate_ff, 1'b1};
   endproperty
   a_period: assert property (p_period)
      else $error("bus clock period wrong");
   property p_pulse_w;
      ev && !wav_ff |=> !wave_output_pin;
   endproperty
   a_pulse_w: assert property (p_pulse_w)
      else $error("pulse wider than one cycle");
   property p_flag_irq;
      ev && !wav_ff && ie_ff |-> ##[0:2] timeout_irq;
   endproperty
   a_flag_irq: assert property (p_flag_irq)
      else $error("time-out without request");
   property p_w1c;
      $fell(timeout_irq) && ie_ff && $past(ie_ff)
         |-> $past(clr1) || $past(clr1, 2) || $past(clr1, 3);
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("flag cleared without write of one");
   property p_off;
      off_ff > 4'h4 && $past(ie_ff, 2) |-> !$rose(timeout_irq);
   endproperty
   a_off: assert property (p_off)
      else $error("time-out while disabled");
   property p_mask;
      irq |-> $past(msk_ff);
   endproperty
   a_mask: assert property (p_mask)
      else $error("interrupt while masked");
endmodule
bind pwt_timer pwt_timer_properties pwt_timer_properties_inst (
   .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
   .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
   .special_mode(special_mode), .flash_trim(flash_trim),
   .wave_output_pin(wave_output_pin), .timeout_irq(timeout_irq),
   .irq(irq)
);
`default_nettype wire

// File: tb/pwt_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pwt_timer_bench;
   import pwt_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic [DATA_W-1:0] rdata;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic special_mode = 1'b0;
   logic [7:0] flash_trim;
   logic wave_output_pin, timeout_irq, irq;
   logic [31:0] seed = 32'h176a80cc;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n, rate;
   int m_reg[16];
   pwt_timer #(.SLOW_TICK(40), .TRIM_STEP(1)) pwt_timer_inst (
      .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .special_mode(special_mode), .flash_trim(flash_trim),
      .wave_output_pin(wave_output_pin), .timeout_irq(timeout_irq),
      .irq(irq)
   );
   always #5 mclk = ~mclk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic chk(input logic ok, input string s);
      cmp_count++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("MISMATCH %0t %s", $time, s);
      end
   endtask
   // Write cycle, then the register model follows it
   task automatic wr(input int i, input logic [7:0] d);
      logic [7:0] m;
      m = m_reg[i][7:0];
      addr <= {10'h2f0 + i[9:0], 2'b00};
      wdata <= {24'h0, d};
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
      @(posedge mclk);
      case (i)
         0: m_reg[0] = {(m[2] | d[2]) ? m[7] : d[7], 2'b0, d[4:1], m[0] & ~d[0]};
         1, 2: if (m_reg[0][2] == 0) m_reg[i] = d;
         3: m_reg[3] = d;
         6: if (special_mode) m_reg[6] = d;
         8: m_reg[8] = m & ~d;
         9: m_reg[9] = d & 8'h01;
         default: ;
      endcase
   endtask
   // Read cycle, data checked in the following cycle
   task automatic rd(input int i, input logic [7:0] m);
      addr <= {10'h2f0 + i[9:0], 2'b00};
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      @(negedge mclk);
      chk(((rdata ^ {24'h0, m_reg[i][7:0]}) & {24'hffffff, m}) === '0, "rd");
      @(posedge mclk);
   endtask
   task automatic wt(input int lim, input int lo);
      n = 0;
      while (timeout_irq !== 1'b1 && n < lim) begin
         @(negedge mclk);
         n++;
      end
      chk(timeout_irq === 1'b1 && n >= lo, "time-out");
      @(posedge mclk);
      m_reg[0][0] = 1'b1;
      m_reg[8] = 1;
   endtask
   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Cycle ceiling against hangs
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end
   initial begin
      seed = xs(seed);
      flash_trim = seed[7:0];
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      m_reg[3] = flash_trim;
      // Reset values, flash trim, unmapped places
      for (int i = 0; i < 10; i++) rd(i, i == 3 ? 8'hfc : 8'hff);
      seed = xs(seed);
      wr(6, seed[7:0]);
      rd(6, 8'hff);
      special_mode <= 1'b1;
      repeat (4) @(posedge mclk);
      wr(6, seed[15:8]);
      rd(6, 8'hff);
      special_mode <= 1'b0;
      wr(7, seed[23:16]);
      rd(7, 8'hff);
      wr(3, seed[31:24]);
      rd(3, 8'hfc);
      // Bus clock source, pulse then clock waveform
      for (int k = 0; k < 2; k++) begin
         seed = xs(seed);
         rate = seed[2:0];
         wr(0, 8'h80);
         wr(1, 8'h00);
         wr(2, rate[7:0]);
         rd(2, 8'hff);
         wr(0, {3'b100, k[0], 4'he});
         wt(2 * rate + 2, 2 * rate + 2);
         wr(2, rate[7:0] + 8'h01);
         rd(2, 8'hff);
         wr(0, {3'b000, k[0], 4'he});
         rd(0, 8'hfe);
         repeat (4 * rate + 12) @(posedge mclk);
         wr(0, {3'b100, k[0], 4'ha});
         rd(0, 8'hff);
         wr(0, {3'b100, k[0], 4'hb});
         rd(0, 8'hff);
      end
      // Status, mask and level interrupt
      wr(9, 8'h01);
      repeat (3) @(negedge mclk);
      chk(irq === 1'b1, "irq unmasked");
      @(posedge mclk);
      wr(9, 8'h00);
      repeat (3) @(negedge mclk);
      chk(irq === 1'b0, "irq masked");
      @(posedge mclk);
      wr(9, 8'h01);
      wr(8, 8'h01);
      repeat (3) @(negedge mclk);
      chk(irq === 1'b0, "irq cleared");
      @(posedge mclk);
      rd(8, 8'hff);
      // Slow source, same write may not switch it
      wr(3, 8'h00);
      wr(0, 8'h00);
      wr(2, 8'h00);
      wr(0, 8'h86);
      wt(640, 320);
      rd(0, 8'hfe);
      wr(0, 8'h03);
      rd(0, 8'hff);
      complete_run();
   end
endmodule
`default_nettype wire
